//--- common/uef_cfg.svh
`ifndef UEF_CFG_SVH
`define UEF_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define UEF_OFS_ERROR_FLAGS   8'h00
`define UEF_OFS_IRQ_STATUS    8'h04
`define UEF_OFS_IRQ_MASK      8'h08
`define UEF_OFS_CONTROL       8'h0c

// Bit positions inside the error flag byte
`define UEF_BIT_STUFF         7
`define UEF_BIT_BUS_MATRIX    6
`define UEF_BIT_DMA           5
`define UEF_BIT_TURNAROUND    4
`define UEF_BIT_FIELD_SIZE    3
`define UEF_BIT_DATA_CRC      2
`define UEF_BIT_TOKEN_OR_EOF  1
`define UEF_BIT_PID_CHECK     0

// Control register fields
`define UEF_CTRL_HOST_MODE    0

// Widths and reset values
`define UEF_FLAG_WIDTH        8
`define UEF_FLAGS_RESET       8'h00
`define UEF_MASK_RESET        8'h00
`define UEF_CTRL_RESET        8'h00

// Idle bit times allowed after an end-of-packet
`define UEF_TURNAROUND_BITS   16

// AXI response codes
`define UEF_RESP_OKAY         2'h0
`define UEF_RESP_SLVERR       2'h2

`endif

//--- common/uef_pkg.sv
package uef_pkg;

  // Error events raised by the USB engine, one-cycle pulses
  typedef struct packed {
    logic       stuff_error;
    logic       bdt_base_invalid;
    logic       buf_addr_invalid;
    logic       dma_late;
    logic       rx_truncated;
    logic       data_end;
    logic [2:0] data_bit_rem;
    logic       data_crc_fail;
    logic       token_crc_fail;
    logic       pid_check_fail;
  } uef_events_type;

  // Link state seen by the turnaround timer and frame check
  typedef struct packed {
    logic eop;
    logic bit_tick;
    logic bus_idle;
    logic await_resp;
    logic tx_active;
    logic rx_active;
    logic frame_count_zero;
  } uef_link_type;

  // Turnaround timer states
  typedef enum logic [0:0] {
    UEF_TMR_OFF   = 1'b0,
    UEF_TMR_COUNT = 1'b1
  } uef_tmr_state_type;

endpackage : uef_pkg

//--- hw/uef_turnaround_timer.sv
`timescale 1ns/1ps
`include "uef_cfg.svh"

module uef_turnaround_timer #(
  parameter int LIMIT_BITS = `UEF_TURNAROUND_BITS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire uef_pkg::uef_link_type link,
  output logic                   timeout
);
  import uef_pkg::*;

  uef_tmr_state_type state_reg;
  logic [5:0]        count_reg;

  ////////////////////////////////////////////////////////////////////////
  // Arm on end-of-packet, count idle bit times, fire past the limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= UEF_TMR_OFF;
      count_reg <= 6'h00;
      timeout   <= 1'b0;
    end else begin
      timeout <= 1'b0;
      unique case (state_reg)
        UEF_TMR_OFF: begin
          count_reg <= 6'h00;
          if (link.eop && link.await_resp) begin
            state_reg <= UEF_TMR_COUNT;
          end
        end
        UEF_TMR_COUNT: begin
          if (!link.bus_idle || !link.await_resp) begin
            state_reg <= UEF_TMR_OFF; // Response began, or none expected
          end else if (link.bit_tick) begin
            if (count_reg == 6'(LIMIT_BITS)) begin
              timeout   <= 1'b1;
              state_reg <= UEF_TMR_OFF;
            end else begin
              count_reg <= count_reg + 6'h01;
            end
          end
        end
      endcase
    end
  end

endmodule : uef_turnaround_timer

//--- hw/uef_error_flags.sv
// Operation
// - Flag packets rejected for bit stuffing
// - Flag invalid descriptor table or buffer address
// - Flag late DMA grant: underflow or overflow
// - Flag truncated packets as DMA error too
// - Flag turnaround time-out past 16 idle bits
// - Flag data fields not whole bytes only
// - Flag data packets rejected for CRC16
// - Bit 1: CRC5 in device, EOF in host
// - Hardware sets, reset clears, write one clears
// - Upper 24 bits read zero, eight flags
`timescale 1ns/1ps
`include "uef_cfg.svh"

module uef_error_flags #(
  parameter int TURNAROUND_BITS = `UEF_TURNAROUND_BITS
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // USB engine events and link state
  input  wire uef_pkg::uef_events_type usb_events,
  input  wire uef_pkg::uef_link_type   usb_link,
  // Flag byte and mode back to the engine, interrupt to the core
  output logic [7:0]                  error_flags,
  output logic                        host_mode,
  output logic                        irq
);
  import uef_pkg::*;

  localparam int FW = `UEF_FLAG_WIDTH;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [FW-1:0] flags_reg;
  logic [FW-1:0] flags_next;
  logic [FW-1:0] irq_status_reg;
  logic [FW-1:0] irq_status_next;
  logic [FW-1:0] irq_mask_reg;
  logic [FW-1:0] ctrl_reg;
  logic [FW-1:0] event_vec;
  logic [FW-1:0] flag_clear;
  logic [FW-1:0] read_byte;
  logic          turnaround_timeout;
  logic          aw_held_reg;
  logic          w_held_reg;
  logic [7:0]    waddr_reg;
  logic [7:0]    wdata_reg;
  logic          wlane0_reg;
  logic          wr_fire;
  logic          rd_fire;
  logic          rd_status_clear;
  logic          frame_end_error;

  ////////////////////////////////////////////////////////////////////////
  // Address decode shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr[7:2] == ofs[7:2]);
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = addr_hit(addr, `UEF_OFS_ERROR_FLAGS) || addr_hit(addr, `UEF_OFS_IRQ_STATUS) ||
                  addr_hit(addr, `UEF_OFS_IRQ_MASK) || addr_hit(addr, `UEF_OFS_CONTROL);
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////
  // Turnaround time-out watch on the idle bus
  uef_turnaround_timer #(
    .LIMIT_BITS (TURNAROUND_BITS)
  ) u_turnaround (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link    (usb_link),
    .timeout (turnaround_timeout)
  );

  ////////////////////////////////////////////////////////////////////////
  // Event gathering into the flag byte layout
  always_comb begin
    frame_end_error = usb_link.frame_count_zero && (usb_link.tx_active || usb_link.rx_active);
    event_vec = '0;
    event_vec[`UEF_BIT_STUFF]      = usb_events.stuff_error;
    event_vec[`UEF_BIT_BUS_MATRIX] = usb_events.bdt_base_invalid
                                   || usb_events.buf_addr_invalid;
    event_vec[`UEF_BIT_DMA]        = usb_events.dma_late
                                   || usb_events.rx_truncated;
    event_vec[`UEF_BIT_TURNAROUND] = turnaround_timeout;
    event_vec[`UEF_BIT_FIELD_SIZE] = usb_events.data_end
                                   && (usb_events.data_bit_rem != 3'h0);
    event_vec[`UEF_BIT_DATA_CRC]   = usb_events.data_crc_fail;
    event_vec[`UEF_BIT_TOKEN_OR_EOF] = ctrl_reg[`UEF_CTRL_HOST_MODE] ? frame_end_error
                                     : usb_events.token_crc_fail;
    event_vec[`UEF_BIT_PID_CHECK]  = usb_events.pid_check_fail;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UEF_RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      waddr_reg     <= 8'h00;
      wdata_reg     <= 8'h00;
      wlane0_reg    <= 1'b0;
    end else begin
      // Address capture
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        waddr_reg     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      // Data capture, only the low lane carries bits
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata[7:0];
        wlane0_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (!w_held_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      // Response once both halves are in
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(waddr_reg) ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, data registered with valid
  assign rd_fire         = s_axi_arvalid && s_axi_arready;
  assign rd_status_clear = rd_fire && addr_hit(s_axi_araddr, `UEF_OFS_IRQ_STATUS);

  always_comb begin
    read_byte = '0;
    if (addr_hit(s_axi_araddr, `UEF_OFS_ERROR_FLAGS)) begin
      read_byte = flags_reg;
    end else if (addr_hit(s_axi_araddr, `UEF_OFS_IRQ_STATUS)) begin
      read_byte = irq_status_reg;
    end else if (addr_hit(s_axi_araddr, `UEF_OFS_IRQ_MASK)) begin
      read_byte = irq_mask_reg;
    end else if (addr_hit(s_axi_araddr, `UEF_OFS_CONTROL)) begin
      read_byte = ctrl_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UEF_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, read_byte};
        s_axi_rresp   <= addr_mapped(s_axi_araddr) ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flags: sticky, write one to clear, set beats clear
  always_comb begin
    flag_clear = '0;
    if (wr_fire && wlane0_reg && addr_hit(waddr_reg, `UEF_OFS_ERROR_FLAGS)) begin
      flag_clear = wdata_reg;
    end
    flags_next = (flags_reg & ~flag_clear) | event_vec;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= `UEF_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by its own read, set wins
  always_comb begin
    irq_status_next = rd_status_clear ? event_vec : (irq_status_reg | event_vec);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= `UEF_FLAGS_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask register plain read-write, control keeps only its host mode bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= `UEF_MASK_RESET;
      ctrl_reg     <= `UEF_CTRL_RESET;
    end else if (wr_fire && wlane0_reg) begin
      if (addr_hit(waddr_reg, `UEF_OFS_IRQ_MASK)) begin
        irq_mask_reg <= wdata_reg;
      end
      if (addr_hit(waddr_reg, `UEF_OFS_CONTROL)) begin
        ctrl_reg <= {7'h00, wdata_reg[`UEF_CTRL_HOST_MODE]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs toward the engine and the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_flags <= `UEF_FLAGS_RESET;
      host_mode   <= 1'b0;
      irq         <= 1'b0;
    end else begin
      error_flags <= flags_next;
      host_mode   <= ctrl_reg[`UEF_CTRL_HOST_MODE];
      irq         <= |(irq_status_next & irq_mask_reg);
    end
  end

endmodule : uef_error_flags

//--- verification/uef_error_flags_chk.sv
`timescale 1ns/1ps
module uef_error_flags_chk #(
  parameter int TURNAROUND_BITS = 16
) (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_rvalid,
  input wire logic [31:0]            s_axi_rdata,
  input wire uef_pkg::uef_events_type usb_events,
  input wire uef_pkg::uef_link_type   usb_link,
  input wire logic [7:0]             error_flags,
  input wire logic                   host_mode
);
  import uef_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       armed_reg;
  logic [5:0] bits_reg;
  wire logic  wait_idle = usb_link.bus_idle && usb_link.await_resp;
  // Idle bit times seen since an armed end-of-packet
  always_ff @(posedge aclk) begin
    if (!aresetn || !wait_idle) begin
      armed_reg <= 1'b0;
      bits_reg  <= 6'h0;
    end else if (usb_link.eop) begin
      armed_reg <= 1'b1;
      bits_reg  <= 6'h0;
    end else if (armed_reg && usb_link.bit_tick) begin
      bits_reg <= bits_reg + 6'h1;
    end
  end
  sequence s_last_tick;
    armed_reg && wait_idle && usb_link.bit_tick && bits_reg == TURNAROUND_BITS;
  endsequence
  sequence s_flag_fell;
    |($past(error_flags) & ~error_flags);
  endsequence
  property p_stuff; usb_events.stuff_error |=> error_flags[7]; endproperty
  property p_matrix;
    usb_events.bdt_base_invalid || usb_events.buf_addr_invalid |=> error_flags[6];
  endproperty
  property p_dma; usb_events.dma_late || usb_events.rx_truncated |=> error_flags[5]; endproperty
  property p_timeout; s_last_tick |-> ##[1:2] error_flags[4]; endproperty
  property p_size; usb_events.data_end && usb_events.data_bit_rem != 3'h0 |=> error_flags[3]; endproperty
  property p_crc; usb_events.data_crc_fail |=> error_flags[2]; endproperty
  property p_bit1;
    (!host_mode && usb_events.token_crc_fail) || (host_mode && usb_link.frame_count_zero &&
      (usb_link.tx_active || usb_link.rx_active)) |=> error_flags[1];
  endproperty
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_hold; s_flag_fell |-> $rose(s_axi_bvalid); endproperty
  a_stuff: assert property (p_stuff) else $error("stuff flag not set");
  a_matrix: assert property (p_matrix) else $error("bus matrix flag not set");
  a_dma: assert property (p_dma) else $error("dma flag not set");
  a_timeout: assert property (p_timeout) else $error("turnaround flag not set");
  a_size: assert property (p_size) else $error("field size flag not set");
  a_crc: assert property (p_crc) else $error("data crc flag not set");
  a_bit1: assert property (p_bit1) else $error("shared bit 1 not set");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_hold: assert property (p_hold) else $error("flag dropped without write");
endmodule : uef_error_flags_chk
bind uef_error_flags uef_error_flags_chk #(.TURNAROUND_BITS(TURNAROUND_BITS)) uef_error_flags_chk_inst (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .usb_events, .usb_link, .error_flags,
  .host_mode);

//--- verification/uef_usb_engine_model.sv
`timescale 1ns/1ps
module uef_usb_engine_model (
  input wire logic              aclk,
  output uef_pkg::uef_events_type usb_events,
  output uef_pkg::uef_link_type   usb_link
);
  import uef_pkg::*;
  initial begin
    usb_events = '0;
    usb_link = '0;
  end
  // One-cycle error event
  task automatic pulse(input uef_events_type e);
    @(posedge aclk);
    usb_events <= e;
    @(posedge aclk);
    usb_events <= '0;
  endtask : pulse
  // End-of-packet, then n idle bit times with no reply
  task automatic idle_bits(input int n);
    @(posedge aclk);
    usb_link <= 7'b1011000;
    repeat (n) begin
      @(posedge aclk);
      usb_link <= 7'b0111000;
      @(posedge aclk);
      usb_link <= 7'b0011000;
    end
    @(posedge aclk);
    usb_link <= '0;
  endtask : idle_bits
  // Frame counter at zero while transmitting
  task automatic frame_end;
    @(posedge aclk);
    usb_link <= 7'b0000101;
    @(posedge aclk);
    usb_link <= '0;
  endtask : frame_end
endmodule : uef_usb_engine_model

//--- verification/uef_error_flags_tb_top.sv
`timescale 1ns/1ps
module uef_error_flags_tb_top;
  import uef_pkg::*;
  logic aclk, aresetn, host_mode, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, error_flags;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  uef_events_type usb_events;
  uef_link_type usb_link;
  int n_errors, n_tests, cyc;
  uef_error_flags #(.TURNAROUND_BITS(16)) uef_error_flags_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .usb_events, .usb_link, .error_flags, .host_mode, .irq);
  uef_usb_engine_model uef_usb_engine_model_inst (.aclk, .usb_events, .usb_link);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp_q = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
  endtask : rd
  // Event for table entry i and the flag it should raise
  function automatic uef_events_type ev(input int i);
    ev = '0;
    case (i)
      0: ev.stuff_error = 1'b1;
      1: ev.bdt_base_invalid = 1'b1;
      2: ev.buf_addr_invalid = 1'b1;
      3: ev.dma_late = 1'b1;
      4: ev.rx_truncated = 1'b1;
      5: ev.data_crc_fail = 1'b1;
      6: ev.token_crc_fail = 1'b1;
      7: ev.pid_check_fail = 1'b1;
      8: ev.data_bit_rem = 3'($urandom_range(7, 1));
      default: ev.data_end = 1'b1;
    endcase
    if (i == 8) ev.data_end = 1'b1;
  endfunction : ev
  function automatic logic [31:0] ebit(input int i);
    case (i)
      0: return 32'h80;
      1, 2: return 32'h40;
      3, 4: return 32'h20;
      5: return 32'h04;
      6: return 32'h02;
      7: return 32'h01;
      8: return 32'h08;
      default: return 32'h00;
    endcase
  endfunction : ebit
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Cut a hung run short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {n_errors, n_tests, cyc} = '0;
    void'($urandom(32'h7525));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 20; a += 4) begin
      rd(8'(a));
      chk("reset value", rd_q, 32'h0);
      chk("read resp", resp_q, (a == 16) ? 32'h2 : 32'h0);
    end
    wr(8'h10, $urandom);
    chk("write resp", resp_q, 32'h2);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      uef_usb_engine_model_inst.pulse(ev(i));
      rd(8'h00);
      chk("flag set", rd_q, ebit(i));
      chk("flag output", error_flags, ebit(i));
      wr(8'h00, $urandom & ~ebit(i));
      rd(8'h00);
      chk("flag held", rd_q, ebit(i));
      wr(8'h00, ebit(i) | ($urandom & 32'hffffff00));
      rd(8'h00);
      chk("flag cleared", rd_q, 32'h0);
    end
    $display("event test done");
    uef_usb_engine_model_inst.idle_bits(16);
    rd(8'h00);
    chk("sixteen idle bits", rd_q, 32'h0);
    uef_usb_engine_model_inst.idle_bits(17);
    rd(8'h00);
    chk("seventeen idle bits", rd_q, 32'h10);
    wr(8'h00, 32'hff);
    $display("turnaround test done");
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c);
    chk("control", rd_q, 32'h1);
    chk("host mode", host_mode, 32'h1);
    uef_usb_engine_model_inst.pulse(ev(6));
    rd(8'h00);
    chk("host token crc", rd_q, 32'h0);
    uef_usb_engine_model_inst.frame_end();
    rd(8'h00);
    chk("end of frame", rd_q, 32'h2);
    wr(8'h00, 32'h2);
    wr(8'h0c, 32'h0);
    $display("host test done");
    rd(8'h04);
    wr(8'h08, 32'h80 | ($urandom & 32'hffffff00));
    uef_usb_engine_model_inst.pulse(ev(0));
    repeat (2) @(posedge aclk);
    chk("irq raised", irq, 32'h1);
    rd(8'h04);
    chk("irq status", rd_q, 32'h80);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 32'h0);
    wr(8'h08, 32'h0);
    uef_usb_engine_model_inst.pulse(ev(3));
    repeat (2) @(posedge aclk);
    chk("irq masked", irq, 32'h0);
    rd(8'h04);
    chk("masked status", rd_q, 32'h20);
    // Low lane strobe off: write answered but ignored
    s_axi_wstrb <= 4'he;
    wr(8'h08, 32'hff);
    chk("lane off resp", resp_q, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'h08);
    chk("lane off ignored", rd_q, 32'h0);
    $display("interrupt test done");
    test_done();
  end
endmodule : uef_error_flags_tb_top
